/* File: pps_ctrl.sv */
/*
  pps_ctrl: main output latch-off, standby restart, alert, on/off
  sequencing, power-good timing and slot address mapping.
  assumes analog comparators and pin pads outside; every status
  input is asynchronous and is synchronised here.
*/
// Behaviour
// RQ1: over-current latches main output off
// RQ2: main short latches main output off
// RQ3: latch clears on request toggle or input loss
// RQ4: standby restarts automatically after fault
// RQ5: tolerate 1 ms over-power bursts at 1%
// RQ6: over-power threshold rating plus 49 A
// RQ7: alert asserts before over-power threshold
// RQ8: alert on thermal warning threshold
// RQ9: thermal alert alone never shuts down
// RQ10: alert within 4 ms of input loss
// RQ11: slot pin low is 0, high 1
// RQ12: identity memory target A0h or A2h; code maps two slot bits to A0h, A2h, A4h or A6h
// RQ13: management target B0h or B2h; code maps two slot bits to B0h, B2h, B4h or B6h
// RQ14: target only on bus, max 100 kHz
// RQ15: host spaces bus commands by 1 ms
// RQ16: alert for listed faults, with amber
// RQ17: request low enables main, high disables
// RQ18: main off within 5 ms of release
// RQ19: regulation between 5 and 400 ms
// RQ20: power-good drops within 5 ms of release
// RQ21: power-good only while all outputs regulate
// RQ22: power-good 100 to 500 ms after regulation
// RQ23: power-good timer held during current limit
// RQ24: host holds request high 1 s to clear
// RQ25: power-good low at least 100 ms per cycle
// RQ26: delays counted from a millisecond tick
`timescale 1ns/1ps

module pps_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST;
      dout <= RST;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : pps_sync

module pps_ctrl #(
  parameter int TICK_CYCLES = pps_pkg::TICK_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSON_N,
  input wire logic AC_OK,
  input wire logic MAIN_OC,
  input wire logic MAIN_SHORT,
  input wire logic SB_FAULT,
  input wire logic PWR_WARN,
  input wire logic PWR_OVER,
  input wire logic THERM_WARN,
  input wire logic GEN_FAIL,
  input wire logic OVER_VOLT,
  input wire logic UNDER_VOLT,
  input wire logic FAN_FAIL,
  input wire logic MAIN_IN_REG,
  input wire logic SB_IN_REG,
  input wire logic CUR_LIMIT,
  input wire logic SLOT_ADDR_BIT0,
  input wire logic SLOT_ADDR_BIT1,
  output logic MAIN_EN,
  output logic SB_EN,
  output logic PWOK,
  output logic ALERT_N_O,
  output logic ALERT_OE,
  output logic AMBER_LED,
  output logic FAULT_LATCHED,
  output logic [7:0] FRU_ADDR,
  output logic [7:0] MGMT_ADDR
);
  import pps_pkg::*;

  logic [SYNC_W-1:0] sync_out;
  logic s_pson_n, s_ac_ok, s_main_oc, s_main_short, s_sb_fault;
  logic s_pwr_warn, s_pwr_over, s_therm, s_gen_fail, s_ov, s_uv;
  logic s_fan, s_main_reg, s_sb_reg, s_cur_limit, s_bit0, s_bit1;

  // every pin passes two flip-flops before use
  pps_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .din({PSON_N, SLOT_ADDR_BIT1, MAIN_OC, MAIN_SHORT, SB_FAULT,
          PWR_WARN, PWR_OVER, THERM_WARN, GEN_FAIL, OVER_VOLT,
          UNDER_VOLT, FAN_FAIL, MAIN_IN_REG, SB_IN_REG, CUR_LIMIT,
          SLOT_ADDR_BIT0, AC_OK}),
    .dout(sync_out)
  );

  assign {s_pson_n, s_bit1, s_main_oc, s_main_short, s_sb_fault,
          s_pwr_warn, s_pwr_over, s_therm, s_gen_fail, s_ov,
          s_uv, s_fan, s_main_reg, s_sb_reg, s_cur_limit,
          s_bit0, s_ac_ok} = sync_out;

  // millisecond tick
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin // RQ26
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // over-power filter: a 1 ms burst can straddle two ticks,
  // so only a third consecutive tick trips
  logic [1:0] pwr_cnt_q;
  logic over_power_trip;

  assign over_power_trip = s_pwr_over && tick_q &&
                           pwr_cnt_q == PWR_TRIP_TICKS - 2'h1; // RQ5 RQ6

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pwr_cnt_q <= '0;
    end else if (!s_pwr_over) begin
      pwr_cnt_q <= '0;
    end else if (tick_q && pwr_cnt_q != PWR_TRIP_TICKS) begin
      pwr_cnt_q <= pwr_cnt_q + 2'h1;
    end
  end

  // cycles of the present over-power run, watched by the burst check
  logic [TICK_W:0] pwr_run_q;

  always_ff @(posedge CLK) begin
    if (!RST_N || !s_pwr_over) begin
      pwr_run_q <= '0;
    end else if (pwr_run_q != '1) begin
      pwr_run_q <= pwr_run_q + 1'b1;
    end
  end

  // latched main fault
  logic pson_prev_q, pson_rise, latch_clr, latch_set, latch_q;
  logic start_fail;
  pps_state_type state_q, state_d;
  logic [MS_W-1:0] ms_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pson_prev_q <= 1'b1;
    end else begin
      pson_prev_q <= s_pson_n;
    end
  end

  assign pson_rise = s_pson_n && !pson_prev_q;
  assign latch_clr = pson_rise || !s_ac_ok; // RQ3
  assign start_fail = state_q == ST_RAMP && ms_q >= REG_MAX_MS; // RQ19
  assign latch_set = s_main_oc || s_main_short || over_power_trip ||
                     start_fail; // RQ1 RQ2

  // a new fault wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_set || (latch_q && !latch_clr); // RQ1 RQ2 RQ3
    end
  end

  // sequencer
  logic on_ok, all_good;

  assign on_ok = !s_pson_n && s_ac_ok && !latch_q; // RQ17
  assign all_good = s_main_reg && s_sb_reg && s_ac_ok; // RQ21

  always_comb begin
    state_d = state_q;
    if (!on_ok) begin
      state_d = ST_OFF; // RQ17 RQ18 RQ20
    end else begin
      case (state_q)
        ST_OFF: state_d = ST_START;
        ST_START: begin
          // first tick may come at once: one more tick keeps the minimum
          if (ms_q > ON_MIN_MS) begin // RQ19
            state_d = ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (all_good) begin
            state_d = ST_PG_WAIT;
          end
        end
        ST_PG_WAIT: begin
          if (all_good && ms_q > PG_DLY_MS) begin // RQ22 RQ25
            state_d = ST_ON;
          end
        end
        ST_ON: begin
          if (!all_good) begin
            state_d = ST_PG_WAIT; // RQ21
          end
        end
        default: state_d = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ms timer restarts on every state change; ramp keeps the start
  // count so the 400 ms bound runs from the request
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ms_q <= '0;
    end else if (state_d != state_q && state_d != ST_RAMP) begin
      ms_q <= '0;
    end else if (state_q == ST_PG_WAIT && (s_cur_limit || !all_good)) begin
      ms_q <= '0; // RQ23
    end else if (tick_q && ms_q != '1) begin
      ms_q <= ms_q + 1'b1; // RQ26
    end
  end

  // outputs
  logic alert_d;

  // thermal and warning inputs only alert, never stop the main rail
  assign alert_d = s_pwr_warn || s_pwr_over || s_therm || s_gen_fail ||
                   s_ov || s_uv || s_fan || s_main_oc || s_sb_fault ||
                   !s_ac_ok || latch_q; // RQ7 RQ8 RQ9 RQ10 RQ16

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      MAIN_EN <= 1'b0;
      PWOK <= 1'b0;
    end else begin
      MAIN_EN <= state_d == ST_RAMP || state_d == ST_PG_WAIT ||
                 state_d == ST_ON; // RQ17 RQ18
      PWOK <= state_d == ST_ON && all_good; // RQ20 RQ21
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SB_EN <= 1'b0;
      FAULT_LATCHED <= 1'b0;
    end else begin
      SB_EN <= !s_sb_fault; // RQ4
      FAULT_LATCHED <= latch_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ALERT_OE <= 1'b0;
      ALERT_N_O <= 1'b1;
      AMBER_LED <= 1'b0;
    end else begin
      ALERT_OE <= alert_d; // RQ16
      ALERT_N_O <= !alert_d;
      AMBER_LED <= alert_d; // RQ16
    end
  end

  // addresses for the target-only bus ports outside
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      FRU_ADDR <= FRU_BASE | SLOT_RST_BITS;
      MGMT_ADDR <= MGMT_BASE | SLOT_RST_BITS;
    end else begin
      FRU_ADDR <= FRU_BASE | {5'h00, s_bit1, s_bit0, 1'b0}; // RQ11 RQ12 RQ14
      MGMT_ADDR <= MGMT_BASE | {5'h00, s_bit1, s_bit0, 1'b0}; // RQ13 RQ14
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_main_latch_off: assert property (latch_q |=> !MAIN_EN) // RQ1
    else $error("main output on while fault latched");
  a_short_latches: assert property (s_main_short |=> latch_q) // RQ2
    else $error("short did not latch fault");
  a_latch_holds: assert property ( // RQ3
    latch_q && !latch_clr |=> latch_q)
    else $error("fault latch cleared without cause");
  a_sb_restart: assert property ( // RQ4
    !s_sb_fault ##1 !s_sb_fault |-> SB_EN)
    else $error("standby not restarted");
  a_pwr_filter: assert property ( // RQ5
    over_power_trip |-> pwr_run_q > (TICK_W + 1)'(TICK_CYCLES))
    else $error("over-power burst tripped early");
  a_alert_pwr: assert property ( // RQ7
    s_pwr_warn |=> ALERT_OE && !ALERT_N_O)
    else $error("no alert ahead of over-power");
  a_alert_therm: assert property ( // RQ8
    s_therm |=> ALERT_OE && AMBER_LED)
    else $error("no alert on thermal warning");
  a_therm_runs: assert property ( // RQ9
    state_q == ST_ON && s_therm && on_ok && all_good |=> MAIN_EN)
    else $error("thermal warning stopped main output");
  a_ac_alert: assert property (!s_ac_ok |=> ALERT_OE) // RQ10
    else $error("input loss alert late");
  a_fru_addr: assert property ( // RQ12
    FRU_ADDR == (FRU_BASE | {5'h00, $past(s_bit1), $past(s_bit0), 1'b0}))
    else $error("identity address wrong");
  a_mgmt_addr: assert property ( // RQ13
    MGMT_ADDR == (MGMT_BASE | {5'h00, $past(s_bit1), $past(s_bit0), 1'b0}))
    else $error("management address wrong");
  a_req_main_off: assert property (s_pson_n |=> !MAIN_EN) // RQ18
    else $error("main output on after release");
  a_req_pwok_off: assert property (s_pson_n |=> !PWOK) // RQ20
    else $error("power-good high after release");
  a_start_delay: assert property ( // RQ19
    $rose(MAIN_EN) |-> $past(ms_q) > ON_MIN_MS)
    else $error("main output enabled too early");
  a_pwok_reg: assert property (PWOK |-> $past(all_good)) // RQ21
    else $error("power-good without regulation");
  a_pwok_delay: assert property ( // RQ22
    $rose(PWOK) |-> $past(ms_q) > PG_DLY_MS)
    else $error("power-good asserted too early");
  a_pg_inhibit: assert property ( // RQ23
    state_q == ST_PG_WAIT && s_cur_limit |=> ms_q == '0)
    else $error("power-good timer ran in current limit");

  c_power_up: cover property ($rose(PWOK));
  c_latch_on: cover property (state_q == ST_ON && latch_set);
  c_pwr_burst: cover property (pwr_cnt_q == 2'h1 && $fell(s_pwr_over));
  c_latch_clear: cover property ($fell(latch_q) && pson_prev_q);

endmodule : pps_ctrl

/* File: pps_host_model.sv */
/*
  pps_host_model: backplane side; main output reports regulation RAMP
  clocks after its enable, standby one clock after; each loses it one clock after disable.
  assumes enables come from pps_ctrl on the same clock.
*/
`timescale 1ns/1ps

module pps_host_model #(
  parameter int RAMP = 20
) (
  input wire logic CLK,
  input wire logic MAIN_EN,
  input wire logic SB_EN,
  output logic MAIN_IN_REG,
  output logic SB_IN_REG
);
  int ramp_q = 0;
  logic sb_q = 1'b0;

  // no early regulation: a real rail needs time to rise
  always_ff @(posedge CLK) begin
    if (!MAIN_EN)
      ramp_q <= 0;
    else if (ramp_q < RAMP)
      ramp_q <= ramp_q + 1;
  end

  always_ff @(posedge CLK) begin
    sb_q <= SB_EN;
  end

  assign MAIN_IN_REG = (ramp_q == RAMP);
  assign SB_IN_REG = sb_q;
endmodule : pps_host_model

/* File: pps_pkg.sv */
/*
  pps_pkg: constants and types for the supply protection and
  sequencing controller.
  assumes a 40 MHz system clock; all delays are counted in ms ticks.
*/
package pps_pkg;

  // clock and millisecond tick
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES_DEF = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 16;
  localparam int MS_W = 10;

  // sequencing times in ms
  localparam logic [9:0] ON_MIN_MS = 10'h005;
  localparam logic [9:0] REG_MAX_MS = 10'h190;
  localparam logic [9:0] PG_DLY_MS = 10'h064;
  localparam logic [9:0] PG_MAX_MS = 10'h1f4;
  localparam logic [9:0] OFF_MAX_MS = 10'h005;
  localparam logic [9:0] AC_ALERT_MAX_MS = 10'h004;
  localparam logic [9:0] THERM_REDUCE_MS = 10'h002;

  // over-power burst filter, in ms ticks
  localparam logic [1:0] PWR_BURST_MS = 2'h1;
  localparam logic [1:0] PWR_TRIP_TICKS = 2'h3;

  // over-power threshold, applied by the analog comparator
  localparam int PWR_MARGIN_A = 49;
  localparam int PWR_TOL_W = 50;

  // bus target addresses
  localparam logic [7:0] FRU_BASE = 8'ha0;
  localparam logic [7:0] MGMT_BASE = 8'hb0;
  // slot bits while the synchronisers sit in reset (pins pulled high)
  localparam logic [7:0] SLOT_RST_BITS = 8'h06;

  // reset values of the synchronised pins
  localparam int SYNC_W = 17;
  localparam logic [16:0] SYNC_RST = 17'h18003;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_START,
    ST_RAMP,
    ST_PG_WAIT,
    ST_ON
  } pps_state_type;

endpackage : pps_pkg

/* File: test_psu_protection_control_signals.sv */
/*
  test_psu_protection_control_signals: directed scenarios for
  pps_ctrl with a 10-cycle ms tick.
  assumes pps_pkg, pps_ctrl and pps_host_model compiled first.
*/
`timescale 1ns/1ps

module test_psu_protection_control_signals;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pson_n = 1'b1;
  logic ac_ok = 1'b1;
  logic main_oc = 1'b0;
  logic main_short = 1'b0;
  logic sb_fault = 1'b0;
  logic pwr_over = 1'b0;
  logic cur_limit = 1'b0;
  logic [5:0] warn = 6'h00;
  logic [1:0] slot = 2'h3;
  logic main_en, sb_en, pwok, alert_n, alert_oe, amber, latched;
  logic main_reg, sb_reg;
  logic [7:0] fru, mgmt;
  int bad_count = 0;
  int total_checks = 0;
  int n;

  always #12.5 clk = ~clk;

  pps_ctrl #(.TICK_CYCLES(10)) i_pps_ctrl (
    .CLK(clk), .RST_N(rst_n), .PSON_N(pson_n), .AC_OK(ac_ok),
    .MAIN_OC(main_oc), .MAIN_SHORT(main_short), .SB_FAULT(sb_fault),
    .PWR_WARN(warn[5]), .PWR_OVER(pwr_over), .THERM_WARN(warn[0]),
    .GEN_FAIL(warn[1]), .OVER_VOLT(warn[2]), .UNDER_VOLT(warn[3]),
    .FAN_FAIL(warn[4]), .MAIN_IN_REG(main_reg), .SB_IN_REG(sb_reg),
    .CUR_LIMIT(cur_limit), .SLOT_ADDR_BIT0(slot[0]),
    .SLOT_ADDR_BIT1(slot[1]), .MAIN_EN(main_en), .SB_EN(sb_en),
    .PWOK(pwok), .ALERT_N_O(alert_n), .ALERT_OE(alert_oe),
    .AMBER_LED(amber), .FAULT_LATCHED(latched), .FRU_ADDR(fru),
    .MGMT_ADDR(mgmt));

  pps_host_model i_pps_host_model (
    .CLK(clk), .MAIN_EN(main_en), .SB_EN(sb_en),
    .MAIN_IN_REG(main_reg), .SB_IN_REG(sb_reg));

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task chkr(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chkr

  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  function logic sel(input int k);
    case (k)
      0: return main_en;
      1: return pwok;
      2: return alert_oe;
      default: return main_reg;
    endcase
  endfunction : sel

  // counts cycles in n; a bound that runs out ends the run
  task wt(input int k, input logic v, input int lim);
    n = 0;
    while (sel(k) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      $display("MISMATCH wait %0d exp %b timed out", k, v);
      complete_run;
    end
  endtask : wt

  task alert_is(input logic v);
    chk("alert_oe", v, alert_oe);
    chk("amber", v, amber);
    chk("alert_n", !v, alert_n);
  endtask : alert_is

  task t_addr;
    for (int i = 0; i < 4; i++) begin
      slot = i[1:0];
      cyc(10);
      chk("fru", 8'ha0 | {5'h00, slot, 1'b0}, fru);
      chk("mgmt", 8'hb0 | {5'h00, slot, 1'b0}, mgmt);
    end
    $display("test addr done");
  endtask : t_addr

  // upper bounds allow one tick of slack for the tick phase;
  // a short release first gives every caller a clean request edge
  task t_power_up;
    pson_n = 1'b1;
    cyc(5);
    pson_n = 1'b0;
    wt(0, 1'b1, 4100);
    chkr("on delay", 50, 4010, n);
    wt(3, 1'b1, 100);
    cur_limit = 1'b1;
    cyc(1100);
    chk("pwok held", 1'b0, pwok);
    cur_limit = 1'b0;
    wt(1, 1'b1, 5100);
    chkr("pg delay", 1000, 5010, n);
    $display("test power up done");
  endtask : t_power_up

  task t_alerts;
    for (int k = 0; k < 6; k++) begin
      warn = 6'h01 << k;
      cyc(5);
      alert_is(1'b1);
      cyc(30);
      if (k == 0)
        chk("main kept", 1'b1, main_en);
      warn = 6'h00;
      cyc(5);
      alert_is(1'b0);
    end
    $display("test alerts done");
  endtask : t_alerts

  task t_pwr;
    repeat (3) begin
      pwr_over = 1'b1;
      cyc(10);
      pwr_over = 1'b0;
      cyc(990);
    end
    chk("pwr latch", 1'b0, latched);
    chk("pwr main", 1'b1, main_en);
    pwr_over = 1'b1;
    cyc(40);
    pwr_over = 1'b0;
    cyc(5);
    chk("pwr trip", 1'b1, latched);
    chk("pwr off", 1'b0, main_en);
    ac_ok = 1'b0;
    cyc(10);
    ac_ok = 1'b1;
    t_power_up;
    $display("test over power done");
  endtask : t_pwr

  task t_sb;
    sb_fault = 1'b1;
    cyc(5);
    chk("sb off", 1'b0, sb_en);
    alert_is(1'b1);
    sb_fault = 1'b0;
    cyc(5);
    chk("sb back", 1'b1, sb_en);
    chk("main kept", 1'b1, main_en);
    $display("test standby done");
  endtask : t_sb

  task t_ac;
    ac_ok = 1'b0;
    wt(2, 1'b1, 45);
    chkr("ac alert", 0, 39, n);
    cyc(5);
    chk("pwok ac", 1'b0, pwok);
    ac_ok = 1'b1;
    t_power_up;
    $display("test input loss done");
  endtask : t_ac

  task t_latch(input logic sc);
    if (sc)
      main_short = 1'b1;
    else
      main_oc = 1'b1;
    cyc(5);
    main_short = 1'b0;
    main_oc = 1'b0;
    cyc(30);
    chk("latched", 1'b1, latched);
    chk("main off", 1'b0, main_en);
    chk("pwok off", 1'b0, pwok);
    alert_is(1'b1);
    if (sc) begin
      ac_ok = 1'b0;
      cyc(10);
      ac_ok = 1'b1;
    end else begin
      pson_n = 1'b1;
      cyc(10000);
    end
    cyc(10);
    chk("cleared", 1'b0, latched);
    t_power_up;
    $display("test latch done");
  endtask : t_latch

  task t_cycle;
    time t0;
    pson_n = 1'b1;
    t0 = $time;
    wt(1, 1'b0, 60);
    chkr("pg off", 0, 50, n);
    wt(0, 1'b0, 60);
    chkr("main off", 0, 50, int'(($time - t0) / 25));
    t0 = $time;
    cyc(20);
    t_power_up;
    chkr("pg low", 1000, 100000, int'(($time - t0) / 25));
    $display("test off on done");
  endtask : t_cycle

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    cyc(5);
    chk("main idle", 1'b0, main_en);
    chk("pwok idle", 1'b0, pwok);
    t_addr;
    t_power_up;
    t_alerts;
    t_pwr;
    t_sb;
    t_ac;
    t_latch(1'b0);
    t_latch(1'b1);
    t_cycle;
    complete_run;
  end
endmodule : test_psu_protection_control_signals
